// ==== rtl/hamming_regs.svh ====
`ifndef HAMMING_REGS_SVH
`define HAMMING_REGS_SVH

// Codeword and information word lengths in bits.
`define CODE_LEN     7
`define INFO_LEN     4
// Index of the last shift in a codeword, counted from zero.
`define LAST_SHIFT   3'h6
// Full count of a received codeword.
`define FULL_COUNT   3'h7
// Depth of the received word buffer.
`define FIFO_DEPTH   32
// Buffer word: error flag, corrected codeword, information word.
`define FIFO_WIDTH   12
// Field positions within a buffer word.
`define FIELD_ERROR   11
`define FIELD_CODE_HI 10
`define FIELD_CODE_LO 4
`define FIELD_WORD_HI 3
// Syndrome values {third, second, first} and the codeword bit each one points at.
`define SYN_BIT_ONE   3'h2
`define SYN_BIT_TWO   3'h1
`define SYN_BIT_THREE 3'h4
`define SYN_BIT_FOUR  3'h6
`define SYN_BIT_FIVE  3'h7
`define SYN_BIT_SIX   3'h3
`define SYN_BIT_SEVEN 3'h5

`endif

// ==== rtl/hamming_pkg.sv ====
package hamming_pkg;
	`include "hamming_regs.svh"

	typedef logic [`CODE_LEN-1:0] code_t;
	typedef logic [`INFO_LEN-1:0] info_t;
	typedef logic [2:0]           count_t;
	typedef logic [2:0]           syndrome_t;

	typedef enum logic {
		enc_idle,
		enc_shift
	} enc_state_e;
endpackage

// ==== rtl/hamming_link_if.sv ====
`timescale 1ns/100ps
interface hamming_link_if;
	logic code_valid;
	logic code_bit;
	logic code_first;
	logic code_ready;

	modport enc (
		output code_valid,
		output code_bit,
		output code_first,
		input  code_ready
	);

	modport chk (
		input  code_valid,
		input  code_bit,
		input  code_first,
		output code_ready
	);
endinterface

// ==== rtl/hamming_encoder.sv ====
`timescale 1ns/100ps
`include "hamming_regs.svh"
module hamming_encoder (
	// Clock and reset.
	input  wire logic              clk_sys,
	input  wire logic              rst_n,
	// Parallel information word from the source.
	input  wire logic              load_valid,
	input  wire hamming_pkg::info_t load_word,
	output logic                   load_ready,
	// Serial codeword link.
	hamming_link_if.enc            link
);
	import hamming_pkg::*;

	enc_state_e state;
	enc_state_e next_state;
	count_t     shift_count;
	count_t     next_shift_count;
	logic       info_stage_first;
	logic       info_stage_second;
	logic       info_stage_third;
	logic       info_stage_last;
	logic       next_info_stage_first;
	logic       next_info_stage_second;
	logic       next_info_stage_third;
	logic       next_info_stage_last;
	logic       feedback_bit;

	// The feedback makes shifts five to seven emit the three check bits.
	assign feedback_bit = info_stage_first ^ info_stage_second ^ info_stage_last;

	assign load_ready      = (state == enc_idle);
	assign link.code_valid = (state == enc_shift);
	assign link.code_bit   = info_stage_last;
	assign link.code_first = (state == enc_shift) && (shift_count == 3'h0);

	always_comb begin
		next_state             = state;
		next_shift_count       = shift_count;
		next_info_stage_first  = info_stage_first;
		next_info_stage_second = info_stage_second;
		next_info_stage_third  = info_stage_third;
		next_info_stage_last   = info_stage_last;
		case (state)
			enc_idle: begin
				if (load_valid) begin
					next_info_stage_first  = load_word[3];
					next_info_stage_second = load_word[2];
					next_info_stage_third  = load_word[1];
					next_info_stage_last   = load_word[0];
					next_shift_count       = 3'h0;
					next_state             = enc_shift;
				end
			end
			enc_shift: begin
				if (link.code_ready) begin
					next_info_stage_first  = feedback_bit;
					next_info_stage_second = info_stage_first;
					next_info_stage_third  = info_stage_second;
					next_info_stage_last   = info_stage_third;
					next_shift_count       = shift_count + 3'h1;
					if (shift_count == `LAST_SHIFT) begin
						next_state = enc_idle;
					end
				end
			end
			default: begin
				next_state = enc_idle;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state             <= enc_idle;
			shift_count       <= 3'h0;
			info_stage_first  <= 1'b0;
			info_stage_second <= 1'b0;
			info_stage_third  <= 1'b0;
			info_stage_last   <= 1'b0;
		end else begin
			state             <= next_state;
			shift_count       <= next_shift_count;
			info_stage_first  <= next_info_stage_first;
			info_stage_second <= next_info_stage_second;
			info_stage_third  <= next_info_stage_third;
			info_stage_last   <= next_info_stage_last;
		end
	end
endmodule

// ==== rtl/hamming_checker.sv ====
`timescale 1ns/100ps
`include "hamming_regs.svh"

// Word buffer; fill counts the words held, so full and empty never alias.
module code_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 32
) (
	// Clock and reset.
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// Filling side.
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	// Draining side.
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic [AW:0]      fill;
	logic [AW-1:0]    next_wr_ptr;
	logic [AW-1:0]    next_rd_ptr;
	logic [AW:0]      next_fill;

	logic             full;
	logic             empty;
	logic             push;
	logic             pop;

	assign full      = (fill == (AW+1)'(DEPTH));
	assign empty     = (fill == '0);
	assign in_ready  = !full;
	assign out_valid = !empty;
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_comb begin
		next_wr_ptr = push ? wr_ptr + AW'(1) : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + AW'(1) : rd_ptr;
		case ({push, pop})
			2'b10:   next_fill = fill + (AW+1)'(1);
			2'b01:   next_fill = fill - (AW+1)'(1);
			default: next_fill = fill;
		endcase
	end

	// The memory has no reset; out_data means nothing while out_valid is low.
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill   <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			fill   <= next_fill;
		end
	end
endmodule

// Behaviour
// - Encoder loads four information bits in parallel.
// - Feedback is first xor second xor last.
// - Seven shifts emit seven codeword bits.
// - Info bits four-seven; check bits by xor.
// - Sixteen words give sixteen distinct codewords.
// - Codewords differ in at least three bits.
// - Checker corrects single errors only.
// - First sum covers bits two, five, six, seven.
// - All sums even passes word unchanged.
// - First, second odd, third even flips six.
module hamming_checker (
	// Clock and reset.
	input  wire logic               clk_sys,
	input  wire logic               rst_n,
	// Serial codeword link.
	hamming_link_if.chk             link,
	// Checked words to the user.
	output logic                    out_valid,
	input  wire logic               out_ready,
	output hamming_pkg::info_t      out_word,
	output hamming_pkg::code_t      out_code,
	output logic                    out_error
);
	import hamming_pkg::*;

	// Receive side: shift vector, bit count and word-complete flag.
	code_t     rx_code;
	code_t     next_rx_code;
	count_t    rx_count;
	count_t    next_rx_count;
	logic      rx_full;
	logic      next_rx_full;
	logic      take;
	logic      fifo_in_ready;

	logic      parity_sum_first;
	logic      parity_sum_second;
	logic      parity_sum_third;
	syndrome_t syndrome;
	code_t     flip_mask;
	code_t     fixed_code;
	logic      code_error;
	info_t     fixed_word;

	logic [`FIFO_WIDTH-1:0] fifo_in_data;
	logic [`FIFO_WIDTH-1:0] fifo_out_data;

	// Bit k of the codeword sits at index k-1; the first bit received is bit seven.
	function automatic code_t mask_of(input syndrome_t syn);
		code_t m;
		m = '0;
		case (syn)
			`SYN_BIT_ONE:   m[0] = 1'b1;
			`SYN_BIT_TWO:   m[1] = 1'b1;
			`SYN_BIT_THREE: m[2] = 1'b1;
			`SYN_BIT_FOUR:  m[3] = 1'b1;
			`SYN_BIT_FIVE:  m[4] = 1'b1;
			`SYN_BIT_SIX:   m[5] = 1'b1;
			`SYN_BIT_SEVEN: m[6] = 1'b1;
			default:        m = '0;
		endcase
		return m;
	endfunction

	// Each sum covers one check bit and the information bits that it protects.
	assign parity_sum_first  = rx_code[1] ^ rx_code[4] ^ rx_code[5] ^ rx_code[6];
	assign parity_sum_second = rx_code[0] ^ rx_code[3] ^ rx_code[4] ^ rx_code[5];
	assign parity_sum_third  = rx_code[2] ^ rx_code[3] ^ rx_code[4] ^ rx_code[6];
	assign syndrome   = {parity_sum_third, parity_sum_second, parity_sum_first};
	assign flip_mask  = mask_of(syndrome);
	// A double error lands on a wrong bit; only single errors are repaired.
	assign fixed_code = rx_code ^ flip_mask;
	assign code_error = (syndrome != 3'h0);

	// Codeword bits four to seven carry the information word, first bit at the bottom.
	assign fixed_word   = {fixed_code[3], fixed_code[4], fixed_code[5], fixed_code[6]};
	assign fifo_in_data = {code_error, fixed_code, fixed_word};

	// A finished word waits here while the buffer is full, stalling the link.
	assign link.code_ready = !rx_full;
	assign take            = link.code_valid && !rx_full;

	// A held word leaves as soon as the buffer has room; the first flag
	// restarts the count, so a word cut short is overwritten by the next.
	always_comb begin
		next_rx_code  = rx_code;
		next_rx_count = rx_count;
		next_rx_full  = rx_full;
		if (rx_full) begin
			if (fifo_in_ready) begin
				next_rx_full  = 1'b0;
				next_rx_count = 3'h0;
			end
		end else if (take) begin
			next_rx_code  = {rx_code[5:0], link.code_bit};
			next_rx_count = link.code_first ? 3'h1 : rx_count + 3'h1;
			next_rx_full  = (next_rx_count == `FULL_COUNT);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rx_code  <= '0;
			rx_count <= 3'h0;
			rx_full  <= 1'b0;
		end else begin
			rx_code  <= next_rx_code;
			rx_count <= next_rx_count;
			rx_full  <= next_rx_full;
		end
	end

	code_fifo #(
		.WIDTH (`FIFO_WIDTH),
		.DEPTH (`FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.in_valid  (rx_full),
		.in_ready  (fifo_in_ready),
		.in_data   (fifo_in_data),
		.out_valid (out_valid),
		.out_ready (out_ready),
		.out_data  (fifo_out_data)
	);

	// Buffer word: error flag, corrected codeword, information word.
	assign out_error = fifo_out_data[`FIELD_ERROR];
	assign out_code  = fifo_out_data[`FIELD_CODE_HI:`FIELD_CODE_LO];
	assign out_word  = fifo_out_data[`FIELD_WORD_HI:0];
endmodule

// ==== test/hamming_link_assertions.sv ====
`timescale 1ns/100ps
module hamming_link_assertions (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst_n,
	// Serial link.
	input wire logic code_valid,
	input wire logic code_bit,
	input wire logic code_first,
	input wire logic code_ready
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic [2:0] cnt;
	logic [5:0] sr;
	wire        tk = code_valid && code_ready;
	// Counts bits taken in a word and keeps the earlier ones for the check.
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			cnt <= 3'h0;
		else if (tk)
			cnt <= (cnt == 3'h6) ? 3'h0 : cnt + 3'h1;
		if (tk)
			sr <= {sr[4:0], code_bit};
	end
	sequence last_bit;
		tk && cnt == 3'h6;
	endsequence
	first_aligned_a: assert property (code_valid |-> code_first == (cnt == 3'h0))
		else $error("first flag out of place");
	first_valid_a: assert property (code_first |-> code_valid)
		else $error("first flag without valid");
	stall_hold_a: assert property (code_valid && !code_ready |=>
		code_valid && $stable(code_bit) && $stable(code_first))
		else $error("bit changed while stalled");
	check_bits_a: assert property (last_bit |-> code_bit == (sr[2] ^ sr[3] ^ sr[4]) &&
		sr[0] == (sr[3] ^ sr[4] ^ sr[5]) && sr[1] == (sr[2] ^ sr[3] ^ sr[5]))
		else $error("check bits wrong");
	word_gap_a: assert property (last_bit |=> !code_valid && !code_ready)
		else $error("no gap after seventh bit");
	bits_run_a: assert property (tk && cnt != 3'h6 |=> code_valid)
		else $error("word cut short");
	ready_drop_a: assert property ($fell(code_ready) |-> $past(tk) && cnt == 3'h0)
		else $error("ready dropped mid word");
	ready_back_a: assert property ($fell(code_ready) |-> ##[1:1000] code_ready)
		else $error("ready never returned");
endmodule

// ==== test/shift_register_hamming_coder_tb.sv ====
`timescale 1ns/100ps
module shift_register_hamming_coder_tb;
	import hamming_pkg::*;
	logic  clk_sys;
	logic  rst_n;
	logic  load_valid;
	info_t load_word;
	logic  load_ready;
	logic  ov [2];
	logic  ordy [2];
	info_t ow [2];
	code_t oc [2];
	logic  oe [2];
	code_t rc [16];
	int    err_count;
	int    samples_checked;
	hamming_link_if l1 ();
	hamming_link_if l2 ();
	hamming_encoder u_hamming_encoder (.clk_sys(clk_sys), .rst_n(rst_n), .load_valid(load_valid),
		.load_word(load_word), .load_ready(load_ready), .link(l1));
	hamming_checker u_hamming_checker (.clk_sys(clk_sys), .rst_n(rst_n), .link(l1),
		.out_valid(ov[0]), .out_ready(ordy[0]), .out_word(ow[0]), .out_code(oc[0]),
		.out_error(oe[0]));
	// Second checker fed by the bench with damaged words.
	hamming_checker u_hamming_checker_inj (.clk_sys(clk_sys), .rst_n(rst_n), .link(l2),
		.out_valid(ov[1]), .out_ready(ordy[1]), .out_word(ow[1]), .out_code(oc[1]),
		.out_error(oe[1]));
	hamming_link_assertions u_hamming_link_assertions (.clk_sys(clk_sys), .rst_n(rst_n),
		.code_valid(l1.code_valid), .code_bit(l1.code_bit), .code_first(l1.code_first),
		.code_ready(l1.code_ready));
	function automatic code_t enc(info_t w);
		return {w[0], w[1], w[2], w[3], w[3] ^ w[2] ^ w[0], w[2] ^ w[1] ^ w[0], w[3] ^ w[2] ^ w[1]};
	endfunction
	task automatic check(string name, logic [11:0] seen, logic [11:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wrap_up();
		if (err_count == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic send(info_t w);
		@(negedge clk_sys);
		load_valid = 1'b1;
		load_word = w;
		while (load_ready !== 1'b1)
			@(negedge clk_sys);
		@(posedge clk_sys);
	endtask
	// Sends a codeword with bit pos (index pos-1) inverted; pos 0 leaves it whole.
	task automatic inject(info_t w, int pos);
		code_t c;
		c = enc(w) ^ code_t'((8'h01 << pos) >> 1);
		for (int i = 6; i >= 0; i--) begin
			@(negedge clk_sys);
			l2.code_valid = 1'b1;
			l2.code_bit = c[i];
			l2.code_first = (i == 6);
			while (l2.code_ready !== 1'b1)
				@(negedge clk_sys);
			@(posedge clk_sys);
		end
		@(negedge clk_sys);
		l2.code_valid = 1'b0;
		l2.code_first = 1'b0;
		l2.code_bit = ~c[0];
	endtask
	task automatic get(int s, info_t w, logic e);
		while (ov[s] !== 1'b1)
			@(negedge clk_sys);
		check("word", {oe[s], oc[s], ow[s]}, {e, enc(w), w});
		@(negedge clk_sys);
	endtask
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	// The tests need about 400 cycles; 800 means a hang.
	initial begin
		#40000;
		err_count++;
		wrap_up();
	end
	initial begin
		err_count = 0;
		samples_checked = 0;
		rst_n = 1'b0;
		load_valid = 1'b0;
		load_word = 4'h0;
		ordy[0] = 1'b0;
		ordy[1] = 1'b1;
		l2.code_valid = 1'b0;
		l2.code_bit = 1'b0;
		l2.code_first = 1'b0;
		repeat (3) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_n = 1'b1;
		for (int i = 0; i < 34; i++)
			send(i[3:0]);
		@(negedge clk_sys);
		load_valid = 1'b0;
		repeat (20) @(negedge clk_sys);
		check("stall", {10'h000, l1.code_ready, load_ready}, 12'h000);
		ordy[0] = 1'b1;
		for (int i = 0; i < 34; i++) begin
			while (ov[0] !== 1'b1)
				@(negedge clk_sys);
			rc[i[3:0]] = oc[0];
			get(0, i[3:0], 1'b0);
		end
		check("drained", {11'h000, ov[0]}, 12'h000);
		for (int i = 0; i < 16; i++)
			for (int j = i + 1; j < 16; j++)
				check("dist", 12'($countones(rc[i] ^ rc[j]) >= 3), 12'h001);
		for (int p = 0; p < 8; p++) begin
			inject(4'(p + 9), p);
			get(1, 4'(p + 9), p != 0);
		end
		check("inj_drained", {11'h000, ov[1]}, 12'h000);
		wrap_up();
	end
endmodule
